/* File: supervisory_watchdog_reset.sv */
// Supervisory watchdog that resets a stalled processor and raises alarm
//
// Summary of operation
// - Trip when no pulse for three seconds
// - Keep resetting processor until pulses return
// - Lamp flickers with each reset cycle
// - Lamp steady on during normal operation
// - Alarm relay after three failed resets
`timescale 1ns/1ps
`default_nettype none
module supervisory_watchdog_reset
#(
  parameter int unsigned TIMEOUT_CYCLES = wdog_pkg::TIMEOUT_CYCLES,
  parameter int unsigned RESET_CYCLES   = wdog_pkg::RESET_CYCLES
)
(
  input  wire logic CLOCK,
  input  wire logic RESET_N,
  input  wire logic CLOCK_ENABLE,
  input  wire logic KEEPALIVE,
  output var  logic CPU_RESET_N,
  output var  logic RESET_LAMP,
  output var  logic ALARM_RELAY
);
  localparam int unsigned CNT_W = $clog2(TIMEOUT_CYCLES + 1);

  wdog_kick_if kick_bus ();

  wdog_kick_sync u_sync
  (
    .clock    (CLOCK),
    .reset_n  (RESET_N),
    .enable   (CLOCK_ENABLE),
    .pin      (KEEPALIVE),
    .kick_out (kick_bus)
  );

  wdog_pkg::wd_state_e           state;
  wdog_pkg::wd_state_e           next_state;
  logic [CNT_W-1:0]              count;
  logic [wdog_pkg::ATTEMPT_W-1:0] attempts;

  wire kick      = kick_bus.kick;
  wire timed_out = (count >= CNT_W'(TIMEOUT_CYCLES - 1));
  wire pulse_end = (count >= CNT_W'(RESET_CYCLES - 1));
  // Lamp off while reset is applied, on while waiting: a visible flicker
  wire lamp_next = (next_state != wdog_pkg::RESETTING);
  wire hit_limit = (attempts >= wdog_pkg::ATTEMPT_W'(wdog_pkg::MAX_ATTEMPTS - 1));
  // A kick must not stretch a reset pulse already under way
  wire restart   = (next_state != state)
                || (kick && state != wdog_pkg::RESETTING);

  always_comb
  begin
    next_state = state;
    unique case (state)
      wdog_pkg::RUN:
        if (!kick && timed_out)
          next_state = wdog_pkg::RESETTING;
      wdog_pkg::RESETTING:
        if (pulse_end)
          next_state = wdog_pkg::WAITING;
      wdog_pkg::WAITING:
        if (kick)
          next_state = wdog_pkg::RUN;
        else if (timed_out)
          next_state = wdog_pkg::RESETTING;
    endcase
  end

  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      state       <= wdog_pkg::RUN;
      count       <= '0;
      attempts    <= wdog_pkg::ATTEMPTS_RESET;
      CPU_RESET_N <= 1'b1;
      RESET_LAMP  <= 1'b1;
      ALARM_RELAY <= 1'b0;
    end
    else if (CLOCK_ENABLE)
    begin
      state       <= next_state;
      count       <= restart ? '0 : count + 1'b1;
      CPU_RESET_N <= (next_state != wdog_pkg::RESETTING);
      RESET_LAMP  <= lamp_next;
      if (kick)
      begin
        attempts    <= wdog_pkg::ATTEMPTS_RESET;
        ALARM_RELAY <= 1'b0;
      end
      else if (state == wdog_pkg::WAITING && next_state == wdog_pkg::RESETTING)
      begin
        // Counter saturates so the alarm stays latched until pulses return
        if (hit_limit)
          ALARM_RELAY <= 1'b1;
        else
          attempts <= attempts + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: wdog_pkg.sv */
// Shared constants for the supervisory watchdog
package wdog_pkg;
  localparam int unsigned CLK_HZ          = 250_000_000;
  localparam int unsigned TIMEOUT_MS      = 3000;
  localparam int unsigned TIMEOUT_CYCLES  = (CLK_HZ / 1000) * TIMEOUT_MS;
  localparam int unsigned RESET_US        = 100;
  localparam int unsigned RESET_CYCLES    = (CLK_HZ / 1_000_000) * RESET_US;
  localparam int unsigned MAX_ATTEMPTS    = 3;
  localparam int unsigned ATTEMPT_W       = 2;
  localparam logic [2:0]  SYNC_RESET      = 3'h0;
  localparam logic [ATTEMPT_W-1:0] ATTEMPTS_RESET = 2'h0;
  typedef enum logic [1:0] {
    RUN,
    RESETTING,
    WAITING
  } wd_state_e;
endpackage

/* File: wdog_kick_if.sv */
// Keep-alive pulse carried from synchroniser to watchdog core
`timescale 1ns/1ps
`default_nettype none
interface wdog_kick_if;
  logic kick;
  modport src (output kick);
  modport dst (input  kick);
endinterface
`default_nettype wire

/* File: wdog_kick_sync.sv */
// Three-stage synchroniser and edge detector for the keep-alive pin
`timescale 1ns/1ps
`default_nettype none
module wdog_kick_sync
(
  input  wire logic     clock,
  input  wire logic     reset_n,
  input  wire logic     enable,
  input  wire logic     pin,
  wdog_kick_if.src      kick_out
);
  logic [2:0] sync;
  logic       level;
  wire        agree = (sync[1] == sync[2]);
  wire        rise  = agree && sync[2] && !level;

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync  <= wdog_pkg::SYNC_RESET;
      level <= 1'b0;
    end
    else if (enable)
    begin
      sync <= {sync[1:0], pin};
      if (agree)
        level <= sync[2];
    end
  end

  // Stage 0 feeds only stage 1; only agreed stages form the edge
  assign kick_out.kick = enable && rise;
endmodule
`default_nettype wire

/* File: wdog_assertions.sv */
// Checker for the watchdog top-level ports
`timescale 1ns/1ps
`default_nettype none
module wdog_assertions
#(
  parameter int unsigned TIMEOUT_CYCLES = 40,
  parameter int unsigned RESET_CYCLES   = 5
)
(
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic KEEPALIVE,
  input wire logic CPU_RESET_N,
  input wire logic RESET_LAMP,
  input wire logic ALARM_RELAY
);
  int unsigned idle;
  int unsigned low_len;
  // Pulse length counted here; repetition counts cannot follow the parameter
  always_ff @(posedge CLOCK or negedge RESET_N)
    if (!RESET_N)
      low_len <= 0;
    else
      low_len <= CPU_RESET_N ? 0 : low_len + 1;
  // Slack covers the pin synchroniser
  always_ff @(posedge CLOCK or negedge RESET_N)
    if (!RESET_N)
      idle <= 0;
    else
      idle <= (KEEPALIVE || !CPU_RESET_N) ? 0 : idle + 1;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);
  AST_TRIP: assert property (idle <= TIMEOUT_CYCLES + 8)
    else $error("no trip");
  AST_PULSE: assert property ($rose(CPU_RESET_N) |->
    low_len == RESET_CYCLES) else $error("pulse length");
  AST_FLICK: assert property ($fell(CPU_RESET_N) |-> !RESET_LAMP)
    else $error("lamp lit");
  AST_STEADY: assert property (CPU_RESET_N |-> RESET_LAMP)
    else $error("lamp dark");
  AST_ALARM: assert property ($rose(ALARM_RELAY) |-> !CPU_RESET_N)
    else $error("alarm");
endmodule
bind supervisory_watchdog_reset wdog_assertions
  #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES), .RESET_CYCLES(RESET_CYCLES))
  i_chk (.CLOCK, .RESET_N,
  .KEEPALIVE, .CPU_RESET_N, .RESET_LAMP, .ALARM_RELAY);
`default_nettype wire

/* File: cpu_model.sv */
// Processor model pulsing the keep-alive pin
`timescale 1ns/1ps
`default_nettype none
module cpu_model
(
  input  wire logic       clock,
  input  wire logic       cpu_reset_n,
  input  wire logic       alive,
  input  wire logic [7:0] period,
  output var  logic       pulse
);
  logic [7:0] count = 8'h00;
  always @(negedge clock)
  begin
    count = (!cpu_reset_n || count >= period) ? 8'h00 : count + 8'h01;
    pulse = alive && cpu_reset_n && count < 8'h03;
  end
endmodule
`default_nettype wire

/* File: supervisory_watchdog_reset_tb.sv */
// Self-checking bench for the watchdog
`timescale 1ns/1ps
`default_nettype none
module supervisory_watchdog_reset_tb;
  `define CHECK(n, e, s) begin comparisons++; if ((s) !== (e)) begin \
    num_errors++; $display("CHECK FAILED %s exp %0h seen %0h", n, e, s); \
    end end
  logic clock = 1'b0, reset_n = 1'b0, alive = 1'b0;
  logic keepalive, cpu_reset_n, lamp, alarm;
  logic [7:0] period = 8'h14;
  logic exp_q[$];
  int num_errors = 0, comparisons = 0, seed = 16;
  initial forever #2 clock = ~clock;
  cpu_model i_cpu (.clock, .cpu_reset_n, .alive, .period, .pulse(keepalive));
  supervisory_watchdog_reset #(.TIMEOUT_CYCLES(40), .RESET_CYCLES(5)) i_dut
    (.CLOCK(clock), .RESET_N(reset_n), .CLOCK_ENABLE(1'b1),
     .KEEPALIVE(keepalive), .CPU_RESET_N(cpu_reset_n),
     .RESET_LAMP(lamp), .ALARM_RELAY(alarm));
  always @(negedge cpu_reset_n)
  begin
    repeat (2) @(negedge clock);
    if (exp_q.size() == 0) `CHECK("spurious", 1'b1, 1'b0)
    else `CHECK("alarm", exp_q.pop_front(), alarm)
    `CHECK("lamp", 1'b0, lamp)
  end
  task summarize;
    $display("Checks %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(negedge clock);
    reset_n = 1'b1;
    alive = 1'b1;
    repeat (4)
    begin
      period = 8'h0a + 8'({$random(seed)} % 25);
      repeat (100) @(negedge clock);
    end
    `CHECK("lamp on", 1'b1, lamp)
    $display("Test kicks done");
    alive = 1'b0;
    exp_q = '{1'b0, 1'b0, 1'b0, 1'b1};
    for (int i = 0; i < 400 && exp_q.size() > 0; i++) @(negedge clock);
    `CHECK("resets", 0, exp_q.size())
    alive = 1'b1;
    repeat (100) @(negedge clock);
    `CHECK("alarm off", 1'b0, alarm)
    `CHECK("lamp back", 1'b1, lamp)
    $display("Test recovery done");
    summarize();
  end
endmodule
`default_nettype wire
